// *** inc/host_port_regs.svh ***
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// Strap level that selects style 16
`define HP_STYLE16_LEVEL 1'b1
// Number of serial channels
`define HP_NUM_CH 4
// Register address width
`define HP_REG_AW 3
// Channel address width in style 68
`define HP_CH_AW 2
// Reset value of the basic-mode flag per channel
`define HP_BASIC_RST 1'b1

`endif

// *** inc/host_port_pkg.sv ***
package host_port_pkg;

	typedef enum logic [1:0] {
		STYLE_16 = 2'b01,
		STYLE_68 = 2'b10
	} bus_style_t;

	// One decoded access toward the channels
	typedef struct packed {
		logic [3:0] ch_sel;
		logic       rd;
		logic       wr;
		logic [2:0] reg_addr;
	} access_t;

endpackage : host_port_pkg

// *** src/irq_merge.sv ***
`timescale 1ns/10ps
`include "host_port_regs.svh"

module irq_merge #(
	parameter int NUM_CH = `HP_NUM_CH
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Channel requests
	input  wire logic [NUM_CH-1:0] ch_irq_i,
	// Open-drain request pin, enable low drives low
	output logic                   irq_o,
	output logic                   irq_oe_b_o
);
	logic any_d;
	logic any_q;

	always_comb begin
		any_d = |ch_irq_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			any_q <= 1'b0;
		end else begin
			any_q <= any_d;
		end
	end

	// Pin only ever pulled low; released otherwise
	assign irq_o      = 1'b0;
	assign irq_oe_b_o = ~any_q;

endmodule : irq_merge

// *** src/host_bus_port.sv ***
`timescale 1ns/10ps
`include "host_port_regs.svh"
// Summary of operation
// - Strap high gives style 16 strobes, selects.
// - Strap low: write pin is direction, read ignored.
// - Style 68 merges channel interrupts, open drain.
// - Variants without strap stay in style 16.
// - Register address decoded same in both styles.
// - Power up in basic mode until programmed.
// - Style 68: shared select plus channel bits.
// - Style 16: each select enables its channel.
// - Third address bit joins register decode.

module host_bus_port #(
	parameter bit HAS_STYLE_PIN = 1'b1,
	parameter int NUM_CH        = `HP_NUM_CH
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// Bus style strap
	input  wire logic              style_sel_i,
	// Host bus pins
	input  wire logic              read_strobe_b_i,
	input  wire logic              write_strobe_b_i,
	input  wire logic [NUM_CH-1:0] per_channel_selects_b_i,
	input  wire logic [1:0]        channel_addr_bits_i,
	input  wire logic              register_addr_bit0_i,
	input  wire logic              register_addr_bit1_i,
	input  wire logic              register_addr_bit2_i,
	// Enhanced features programmed per channel
	input  wire logic [NUM_CH-1:0] enh_prog_i,
	// Channel interrupts
	input  wire logic [NUM_CH-1:0] channel_interrupt_outputs_i,
	// Decoded access toward channels
	output host_port_pkg::access_t acc_o,
	output host_port_pkg::bus_style_t style_o,
	output logic [NUM_CH-1:0]      basic_mode_o,
	// Interrupt pins
	output logic [NUM_CH-1:0]      ch_irq_o,
	output logic                   irq_o,
	output logic                   irq_oe_b_o
);
	host_port_pkg::bus_style_t style_d;
	host_port_pkg::bus_style_t style_q;
	host_port_pkg::access_t    acc_d;
	host_port_pkg::access_t    acc_q;
	logic [NUM_CH-1:0]         basic_d;
	logic [NUM_CH-1:0]         basic_q;
	logic [NUM_CH-1:0]         sel68;
	logic [NUM_CH-1:0]         irq_d;
	logic [NUM_CH-1:0]         irq_q;
	logic [NUM_CH-1:0]         irq68;
	logic                      sel_any;

	// Strap re-sampled each cycle; board keeps it static
	always_comb begin
		if (HAS_STYLE_PIN && style_sel_i != `HP_STYLE16_LEVEL) begin
			style_d = host_port_pkg::STYLE_68;
		end else begin
			style_d = host_port_pkg::STYLE_16;
		end
	end

	// One-hot channel decode from the shared select
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign sel68[g] = !per_channel_selects_b_i[0] &&
				(channel_addr_bits_i == 2'(g));
		end
	endgenerate

	always_comb begin
		acc_d = '0;
		acc_d.reg_addr = {register_addr_bit2_i, register_addr_bit1_i,
			register_addr_bit0_i};
		case (style_q)
			host_port_pkg::STYLE_16: begin
				acc_d.ch_sel = ~per_channel_selects_b_i;
				sel_any      = |acc_d.ch_sel;
				acc_d.rd     = sel_any && !read_strobe_b_i;
				acc_d.wr     = sel_any && !write_strobe_b_i;
			end
			host_port_pkg::STYLE_68: begin
				// Read strobe pin not looked at here
				acc_d.ch_sel = sel68;
				sel_any      = |sel68;
				acc_d.rd     = sel_any && write_strobe_b_i;
				acc_d.wr     = sel_any && !write_strobe_b_i;
			end
			default: begin
				sel_any = 1'b0;
			end
		endcase
	end

	// Basic mode until software enables extras
	always_comb begin
		basic_d = basic_q & ~enh_prog_i;
	end

	always_comb begin
		if (style_q == host_port_pkg::STYLE_68) begin
			irq_d = '0;
		end else begin
			irq_d = channel_interrupt_outputs_i;
		end
	end
	assign irq68 = (style_q == host_port_pkg::STYLE_68) ?
		channel_interrupt_outputs_i : '0;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			style_q <= host_port_pkg::STYLE_16;
			acc_q   <= '0;
			basic_q <= {NUM_CH{`HP_BASIC_RST}};
			irq_q   <= '0;
		end else begin
			style_q <= style_d;
			acc_q   <= acc_d;
			basic_q <= basic_d;
			irq_q   <= irq_d;
		end
	end

	irq_merge #(
		.NUM_CH(NUM_CH)
	) u_irq (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.ch_irq_i   (irq68),
		.irq_o      (irq_o),
		.irq_oe_b_o (irq_oe_b_o)
	);

	assign acc_o        = acc_q;
	assign style_o      = style_q;
	assign basic_mode_o = basic_q;
	assign ch_irq_o     = irq_q;

	// Assertions
	sequence s_wr_seen;
		!write_strobe_b_i && (style_q == host_port_pkg::STYLE_68) &&
			!per_channel_selects_b_i[0];
	endsequence

	// Style 68 access of either direction
	sequence s_sel68_seen;
		(style_q == host_port_pkg::STYLE_68) &&
			!per_channel_selects_b_i[0];
	endsequence

	// Bus idle: every select high in style 16, shared select high in style 68
	sequence s_idle16;
		(style_q == host_port_pkg::STYLE_16) &&
			(&per_channel_selects_b_i);
	endsequence

	sequence s_idle68;
		(style_q == host_port_pkg::STYLE_68) &&
			per_channel_selects_b_i[0];
	endsequence

	sequence s_rd16_seen;
		(style_q == host_port_pkg::STYLE_16) && !read_strobe_b_i &&
			!(&per_channel_selects_b_i);
	endsequence

	// Merge has one register stage: pin follows one cycle late
	sequence s_irq68_seen;
		(style_q == host_port_pkg::STYLE_68) &&
			(|channel_interrupt_outputs_i);
	endsequence

	a_wr68_decode: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_wr_seen |=> acc_o.wr && !acc_o.rd)
		else $error("style 68 write not decoded");
	a_rd_ignored: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_68) && write_strobe_b_i
		&& !per_channel_selects_b_i[0] |=> acc_o.rd && !acc_o.wr)
		else $error("style 68 read not decoded");
	a_sel16_pass: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_16) |=>
		acc_o.ch_sel == ~$past(per_channel_selects_b_i))
		else $error("style 16 select mismatch");
	a_ch68_onehot: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_68) |=> $onehot0(acc_o.ch_sel))
		else $error("style 68 select not one-hot");
	a_ch68_pick: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_sel68_seen |=>
		acc_o.ch_sel == (4'h1 << $past(channel_addr_bits_i)))
		else $error("style 68 wrong channel picked");
	a_idle16_quiet: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_idle16 |=> !acc_o.rd && !acc_o.wr && (acc_o.ch_sel == '0))
		else $error("style 16 access without select");
	a_idle68_quiet: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_idle68 |=> !acc_o.rd && !acc_o.wr && (acc_o.ch_sel == '0))
		else $error("style 68 access without select");
	a_rd16_decode: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_rd16_seen |=> acc_o.rd)
		else $error("style 16 read not decoded");
	a_regaddr_same: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> acc_o.reg_addr == $past({register_addr_bit2_i,
		register_addr_bit1_i, register_addr_bit0_i}))
		else $error("register address mismatch");
	a_irq_merge: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		s_irq68_seen |=> !irq_oe_b_o)
		else $error("merged interrupt not driven");
	a_irq_release: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_68) &&
		!(|channel_interrupt_outputs_i) |=> irq_oe_b_o)
		else $error("merged interrupt not released");
	a_irq16_quiet: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_16)[*2] |-> irq_oe_b_o)
		else $error("open drain driven in style 16");
	a_irq68_mute: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_68) |=> ch_irq_o == '0)
		else $error("per channel request shown in style 68");
	a_irq16_pass: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(style_q == host_port_pkg::STYLE_16) |=>
		ch_irq_o == $past(channel_interrupt_outputs_i))
		else $error("per channel request lost in style 16");
	a_no_strap16: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		!HAS_STYLE_PIN |=> style_o == host_port_pkg::STYLE_16)
		else $error("strapless variant left style 16");
	a_style_follow: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		HAS_STYLE_PIN && style_sel_i |=> style_o == host_port_pkg::STYLE_16)
		else $error("strap high not style 16");
	a_style68_follow: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		HAS_STYLE_PIN && !style_sel_i |=>
		style_o == host_port_pkg::STYLE_68)
		else $error("strap low not style 68");
	a_basic_hold: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		(enh_prog_i == '0) |=> basic_mode_o == $past(basic_mode_o))
		else $error("basic mode left without programming");
	a_basic_sticky: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> (basic_mode_o & ~$past(basic_mode_o)) == '0)
		else $error("basic mode came back without reset");
	a_basic_clear: assert property (
		@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> (basic_mode_o & $past(enh_prog_i)) == '0)
		else $error("programmed channel still in basic mode");

endmodule : host_bus_port

// *** test/host_cpu_model.sv ***
`timescale 1ns/10ps
module host_cpu_model (
	// Request from bench
	input  wire logic       style16_i,
	input  wire logic       sel_i,
	input  wire logic       wr_i,
	input  wire logic [1:0] ch_i,
	input  wire logic [2:0] addr_i,
	// Host bus pins
	output logic            rd_b_o,
	output logic            wr_b_o,
	output logic [3:0]      cs_b_o,
	output logic [1:0]      ch_o,
	output logic [2:0]      a_o
);
	always_comb begin
		a_o    = addr_i;
		wr_b_o = ~wr_i;
		if (style16_i) begin
			// Idle cycles release every select
			cs_b_o = sel_i ? ~(4'h1 << ch_i) : 4'hF;
			rd_b_o = wr_i;
			ch_o   = ~ch_i; // Unused lines keep moving
		end else begin
			// Unused pins toggle so a decoder reading them shows up
			cs_b_o = {addr_i, ~sel_i};
			rd_b_o = addr_i[0];
			ch_o   = ch_i;
		end
	end
endmodule : host_cpu_model

// *** test/tb_quad_uart_host_bus_mode_select.sv ***
`timescale 1ns/10ps
module tb_quad_uart_host_bus_mode_select;
	logic                      clk = 1'b0, rst_b = 1'b0, style = 1'b1;
	logic                      wr = 1'b0, rd_b, wr_b, irq_o, oe_b;
	logic                      sel = 1'b0;
	logic [1:0]                ch = 2'h0, cha;
	logic [2:0]                addr = 3'h0, a;
	logic [3:0]                enh = 4'h0, irq = 4'h0, cs_b, chirq, basic;
	logic [3:0]                i1, e1, eb;
	host_port_pkg::access_t    acc, ea;
	host_port_pkg::bus_style_t sty, sty2;
	int                        num_errors = 0, n_checks = 0, seed = 11;
	bit                        v;

	initial forever #25 clk = ~clk;

	host_cpu_model cpu (.style16_i(style), .sel_i(sel), .wr_i(wr),
		.ch_i(ch), .addr_i(addr), .rd_b_o(rd_b), .wr_b_o(wr_b),
		.cs_b_o(cs_b), .ch_o(cha), .a_o(a));
	host_bus_port dut (.clk_i(clk), .rst_b_i(rst_b), .style_sel_i(style),
		.read_strobe_b_i(rd_b), .write_strobe_b_i(wr_b),
		.per_channel_selects_b_i(cs_b), .channel_addr_bits_i(cha),
		.register_addr_bit0_i(a[0]), .register_addr_bit1_i(a[1]),
		.register_addr_bit2_i(a[2]), .enh_prog_i(enh),
		.channel_interrupt_outputs_i(irq), .acc_o(acc), .style_o(sty),
		.basic_mode_o(basic), .ch_irq_o(chirq), .irq_o(irq_o),
		.irq_oe_b_o(oe_b));
	// Strapless variant sees the same pins
	host_bus_port #(.HAS_STYLE_PIN(1'b0)) dut_fixed (.clk_i(clk),
		.rst_b_i(rst_b), .style_sel_i(style), .read_strobe_b_i(rd_b),
		.write_strobe_b_i(wr_b), .per_channel_selects_b_i(cs_b),
		.channel_addr_bits_i(cha), .register_addr_bit0_i(a[0]),
		.register_addr_bit1_i(a[1]), .register_addr_bit2_i(a[2]),
		.enh_prog_i(enh), .channel_interrupt_outputs_i(irq), .acc_o(),
		.style_o(sty2), .basic_mode_o(), .ch_irq_o(), .irq_o(),
		.irq_oe_b_o());

	task automatic chk_acc(input host_port_pkg::access_t g, e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_acc

	task automatic chk_v(input logic [7:0] g, e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_v

	task automatic complete_run;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run

	function automatic host_port_pkg::access_t exp_acc(logic w,
		logic [1:0] c, logic [2:0] ad, logic sl);
		if (sl) begin
			exp_acc = '{ch_sel: 4'h1 << c, rd: ~w, wr: w, reg_addr: ad};
		end else begin
			exp_acc = '{ch_sel: 4'h0, rd: 1'b0, wr: 1'b0, reg_addr: ad};
		end
	endfunction : exp_acc

	task automatic phase(input logic s);
		@(posedge clk);
		rst_b <= 1'b0;
		style <= s;
		irq   <= 4'h0;
		enh   <= 4'h0;
		repeat (5) @(posedge clk);
		#1;
		chk_acc(acc, '0);
		chk_v({basic, chirq}, 8'hF0);
		chk_v({irq_o, oe_b}, 8'h01);
		chk_v(8'(sty), 8'(host_port_pkg::STYLE_16));
		// Release on an edge so the bench never races sampling
		@(posedge clk);
		rst_b <= 1'b1;
		{v, i1, e1, eb} = {1'b0, 8'h00, 4'hF};
		for (int n = 0; n < 400; n++) begin
			@(posedge clk);
			// First cycles idle, partial programming at n 200 and at random cycles
			sel  <= (n < 2) ? 1'b0 : (3'($random(seed)) != 3'h0);
			wr   <= 1'($random(seed));
			ch   <= 2'($random(seed));
			addr <= 3'($random(seed));
			irq  <= 4'($random(seed));
			if (n == 200) begin
				enh <= 4'h5;
			end else if (4'($random(seed)) == 4'h0) begin
				enh <= 4'($random(seed));
			end else begin
				enh <= 4'h0;
			end
			#1;
			eb = eb & ~e1;
			if (v) begin
				chk_acc(acc, ea);
				chk_v(8'(sty), s ? 8'h01 : 8'h02);
				chk_v({basic, chirq}, {eb, s ? i1 : 4'h0});
				chk_v({irq_o, oe_b}, {7'h00, s | ~|i1});
				chk_v(8'(sty2), 8'(host_port_pkg::STYLE_16));
			end
			{v, i1, e1} = {1'b1, irq, enh};
			ea = exp_acc(wr, ch, addr, sel);
		end
	endtask : phase

	initial begin
		phase(1'b1);
		phase(1'b0);
		complete_run();
	end

	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule : tb_quad_uart_host_bus_mode_select
